// ### hw/smcp_sync.sv
package smcp_pkg;

  // ----------------------------------------
  // Serial word layout
  // ----------------------------------------
  localparam logic [4:0] CNT_DATA   = 5'h08;
  localparam logic [4:0] CNT_WORD   = 5'h10;
  localparam logic [4:0] CNT_WRAP   = 5'h17;
  localparam int         DIR_BIT    = 15;
  localparam int         IDX_MSB    = 14;
  localparam int         IDX_LSB    = 8;

  // ----------------------------------------
  // Mode register space
  // ----------------------------------------
  localparam int         NREG          = 20;
  localparam logic [6:0] IDX_FIRST     = 7'h01;
  localparam logic [6:0] IDX_LAST      = 7'h13;
  localparam logic [6:0] IDX_RSV_LO    = 7'h0d;
  localparam logic [6:0] IDX_RSV_HI    = 7'h0f;
  localparam int         IDX_READ_CTRL = 11;
  localparam int         INC_BIT       = 7;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_READ_CTRL = 8'h01;

  // ----------------------------------------
  // APB map
  // ----------------------------------------
  localparam logic [11:0] OFS_MODE_LAST = 12'h04c;
  localparam logic [11:0] OFS_CTRL      = 12'h080;
  localparam logic [11:0] OFS_STAT      = 12'h084;
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        RST_CTRL_EN   = 1'b1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_MOS_NS      = 30;
  localparam int MOS_CYC       = T_MOS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SMCP_IDLE  = 2'b01,
    SMCP_FRAME = 2'b10
  } smcp_state_t;

endpackage

module smcp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg <= '1;
      sync_out   <= '1;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// ### hw/smcp_port.sv
// Functional notes
// - Four-wire port, asynchronous to audio; bit clock, strobe, data in, data out.
// - Write word is 16 bits: direction, seven-bit index, eight data bits.
// - Most significant bit is direction; zero means write.
// - Bits 14..8 select register, low byte is data for writes.
// - On strobe rise after sixteen pulses, data byte stored at index.
// - Direction one means read from pointer in register 11, index ignored.
// - Single read: output floats eight bits, then drives addressed register.
// - Auto-step set: successive registers read from pointer onward.
// - Auto-step read starts at first strobe fall after register 11 write.
// - During auto-step read, input bits after control word ignored.
// - Auto-step read floats eight clocks, then one byte per register.
// - Past register 19 the auto-step read wraps to register 1.
// - Readback output updates after each falling bit clock edge.
module smcp_port (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Control port pins
  input  wire logic        ctrl_bit_clock,
  input  wire logic        latch_strobe,
  input  wire logic        ctrl_serial_in,
  output logic             ctrl_serial_out,
  output logic             ctrl_serial_out_oe,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] pins_s;
  logic       mc_s, ml_s, sin_s;
  logic       mc_d_reg, ml_d_reg;
  logic       mc_rise, mc_fall, ml_rise, ml_fall;

  // Same depth on all three pins keeps strobe/clock/data ordering intact
  smcp_sync #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({ctrl_bit_clock, latch_strobe, ctrl_serial_in}),
    .sync_out (pins_s)
  );

  assign mc_s    = pins_s[2];
  assign ml_s    = pins_s[1];
  assign sin_s   = pins_s[0];
  assign mc_rise = mc_s & ~mc_d_reg;
  assign mc_fall = ~mc_s & mc_d_reg;
  assign ml_rise = ml_s & ~ml_d_reg;
  assign ml_fall = ~ml_s & ml_d_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mc_d_reg <= 1'b0;
      ml_d_reg <= 1'b1;
    end
    else
    begin
      mc_d_reg <= mc_s;
      ml_d_reg <= ml_s;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  smcp_pkg::smcp_state_t state_reg, state_next;
  logic [15:0] shift_reg, shift_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        dir_reg, dir_next;
  logic        inc_reg, inc_next;
  logic [6:0]  ptr_reg, ptr_next;
  logic [7:0]  byte_reg, byte_next;
  logic        out_reg, out_next;
  logic        oe_reg, oe_next;
  logic [7:0]  mode_reg [smcp_pkg::NREG];
  logic        en_reg, en_next;
  logic [6:0]  last_idx_reg, last_idx_next;
  logic        wr_en;
  logic        reload;
  logic [7:0]  rd_byte;
  logic [6:0]  wr_idx;

  // Reserved and absent indices neither store nor read back
  function automatic logic idx_ok(input logic [6:0] idx);
    idx_ok = (idx >= smcp_pkg::IDX_FIRST) && (idx <= smcp_pkg::IDX_LAST) &&
             !((idx >= smcp_pkg::IDX_RSV_LO) && (idx <= smcp_pkg::IDX_RSV_HI));
  endfunction

  function automatic logic [7:0] mode_rd(input logic [6:0] idx);
    mode_rd = 8'h00;
    for (int i = 0; i < smcp_pkg::NREG; i++)
      if (idx_ok(idx) && idx == 7'(i))
        mode_rd = mode_reg[i];
  endfunction

  assign wr_idx  = shift_reg[smcp_pkg::IDX_MSB:smcp_pkg::IDX_LSB];
  assign rd_byte = mode_rd(ptr_reg);
  assign reload  = (state_reg == smcp_pkg::SMCP_FRAME) && !ml_rise && en_reg && mc_fall && dir_reg &&
                   ((cnt_reg == smcp_pkg::CNT_DATA) || (cnt_reg == smcp_pkg::CNT_WORD));

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    dir_next   = dir_reg;
    inc_next   = inc_reg;
    ptr_next   = ptr_reg;
    byte_next  = byte_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    wr_en      = 1'b0;
    case (state_reg)
      smcp_pkg::SMCP_IDLE:
      begin
        oe_next = 1'b0;
        if (ml_fall && en_reg)
        begin
          // Pointer and step mode fixed per frame from register 11
          state_next = smcp_pkg::SMCP_FRAME;
          cnt_next   = 5'h00;
          dir_next   = 1'b0;
          ptr_next   = mode_reg[smcp_pkg::IDX_READ_CTRL][6:0];
          inc_next   = mode_reg[smcp_pkg::IDX_READ_CTRL][smcp_pkg::INC_BIT];
        end
      end
      smcp_pkg::SMCP_FRAME:
      begin
        if (ml_rise || !en_reg)
        begin
          // Write only when at least a full word arrived; pulses after the sixteenth are ignored
          wr_en      = ml_rise && en_reg && !dir_reg && (cnt_reg == smcp_pkg::CNT_WORD) &&
                       idx_ok(wr_idx);
          state_next = smcp_pkg::SMCP_IDLE;
          oe_next    = 1'b0;
        end
        else
        begin
          if (mc_rise)
          begin
            if (cnt_reg < smcp_pkg::CNT_WORD && !(dir_reg && cnt_reg >= smcp_pkg::CNT_DATA))
              shift_next = {shift_reg[14:0], sin_s};
            if (cnt_reg == 5'h00)
              dir_next = sin_s;
            if (dir_reg && cnt_reg == smcp_pkg::CNT_WRAP)
              cnt_next = smcp_pkg::CNT_WORD;
            else if (!(cnt_reg == smcp_pkg::CNT_WORD && !dir_reg))
              cnt_next = cnt_reg + 5'h01;
          end
          if (mc_fall && dir_reg && cnt_reg >= smcp_pkg::CNT_DATA)
          begin
            if (reload)
            begin
              byte_next = rd_byte;
              out_next  = rd_byte[7];
              oe_next   = 1'b1;
              if (inc_reg)
                ptr_next = (ptr_reg >= smcp_pkg::IDX_LAST) ? smcp_pkg::IDX_FIRST : ptr_reg + 7'h01;
            end
            else
              out_next = byte_reg[~cnt_reg[2:0]];
          end
        end
      end
      default:
      begin
        state_next = smcp_pkg::SMCP_IDLE;
        oe_next    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= smcp_pkg::SMCP_IDLE;
      shift_reg <= 16'h0000;
      cnt_reg   <= 5'h00;
      dir_reg   <= 1'b0;
      inc_reg   <= 1'b0;
      ptr_reg   <= 7'h00;
      byte_reg  <= 8'h00;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      dir_reg   <= dir_next;
      inc_reg   <= inc_next;
      ptr_reg   <= ptr_next;
      byte_reg  <= byte_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  assign ctrl_serial_out    = out_reg;
  assign ctrl_serial_out_oe = oe_reg;

  // ----------------------------------------
  // Mode registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < smcp_pkg::NREG; i++)
        mode_reg[i] <= (i == smcp_pkg::IDX_READ_CTRL) ? smcp_pkg::RST_READ_CTRL : smcp_pkg::RST_MODE;
    end
    else if (wr_en)
    begin
      for (int i = 0; i < smcp_pkg::NREG; i++)
        if (wr_idx == 7'(i))
          mode_reg[i] <= shift_reg[7:0];
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic        apb_setup, apb_wr, addr_ok;
  logic [31:0] rdata_next;

  assign pready    = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign addr_ok   = (paddr[1:0] == 2'b00) &&
                     ((paddr <= smcp_pkg::OFS_MODE_LAST) || (paddr == smcp_pkg::OFS_CTRL) ||
                      (paddr == smcp_pkg::OFS_STAT));
  // Mode registers belong to the serial host; APB only mirrors them
  assign pslverr   = psel && penable && (!addr_ok || (pwrite && paddr != smcp_pkg::OFS_CTRL));

  always_comb
  begin
    rdata_next    = 32'h0000_0000;
    en_next       = en_reg;
    last_idx_next = wr_en ? wr_idx : last_idx_reg;
    if (paddr <= smcp_pkg::OFS_MODE_LAST)
      rdata_next = {24'h00_0000, mode_rd(paddr[8:2])};
    else if (paddr == smcp_pkg::OFS_CTRL)
      rdata_next = {31'h0000_0000, en_reg};
    else if (paddr == smcp_pkg::OFS_STAT)
      rdata_next = {16'h0000, 1'b0, last_idx_reg, 3'h0, inc_reg, dir_reg, oe_reg,
                    state_reg == smcp_pkg::SMCP_FRAME, 1'b0};
    if (apb_wr && paddr == smcp_pkg::OFS_CTRL)
      en_next = pwdata[smcp_pkg::CTRL_EN_BIT];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata       <= 32'h0000_0000;
      en_reg       <= smcp_pkg::RST_CTRL_EN;
      last_idx_reg <= 7'h00;
    end
    else
    begin
      if (apb_setup)
        prdata <= rdata_next;
      en_reg       <= en_next;
      last_idx_reg <= last_idx_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_WRITE_STORES: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en |=> mode_rd($past(wr_idx)) == $past(shift_reg[7:0]))
    else $error("write word not stored");
  AST_READ_NO_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == smcp_pkg::SMCP_FRAME && dir_reg) |-> !wr_en)
    else $error("read frame wrote a register");
  AST_FLOAT_FIRST8: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == smcp_pkg::SMCP_FRAME && cnt_reg < smcp_pkg::CNT_DATA) |-> !oe_reg)
    else $error("output driven during first eight bits");
  AST_FLOAT_ON_RISE: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == smcp_pkg::SMCP_FRAME && ml_rise) |=> !oe_reg ##1 !oe_reg)
    else $error("output not released at strobe rise");
  AST_MSB_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
    reload |=> oe_reg && ctrl_serial_out == $past(rd_byte[7]))
    else $error("readback byte not started with its top bit");
  AST_FALL_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(out_reg) |-> $past(mc_fall))
    else $error("readback changed away from a falling edge");
  AST_STEP: assert property (@(posedge ref_clk) disable iff (rst)
    (reload && inc_reg && ptr_reg < smcp_pkg::IDX_LAST) |=> ptr_reg == $past(ptr_reg) + 7'h01)
    else $error("auto-step pointer did not advance");
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (reload && inc_reg && ptr_reg == smcp_pkg::IDX_LAST) |=> ptr_reg == smcp_pkg::IDX_FIRST)
    else $error("auto-step pointer did not wrap");
  AST_PTR_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == smcp_pkg::SMCP_IDLE && ml_fall && en_reg) |=>
      ptr_reg == $past(mode_reg[smcp_pkg::IDX_READ_CTRL][6:0]))
    else $error("read pointer not taken at strobe fall");
  AST_SAMPLE: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == smcp_pkg::SMCP_FRAME && mc_rise && !ml_rise && en_reg && cnt_reg < smcp_pkg::CNT_DATA)
      |=> shift_reg[0] == $past(sin_s))
    else $error("input bit not sampled on rising edge");
  AST_IGNORE: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == smcp_pkg::SMCP_FRAME && dir_reg && cnt_reg >= smcp_pkg::CNT_DATA) |=> $stable(shift_reg))
    else $error("input taken after control word on read");

endmodule

// ### testbench/smcp_host_model.sv
module smcp_host_model (
  // Control port pins
  output logic ctrl_bit_clock,
  output logic latch_strobe,
  output logic ctrl_serial_in,
  input  wire logic ctrl_serial_out,
  input  wire logic ctrl_serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Pins idle: strobe high, clock low
  // ----------------------------------------
  initial
  begin
    ctrl_bit_clock = 1'b0;
    latch_strobe   = 1'b1;
    ctrl_serial_in = 1'b0;
  end

  // ----------------------------------------
  // One frame of nclk pulses, MSB first
  // ----------------------------------------
  // Bits after the word toggle, so an ignored input still moves
  task automatic frame(input logic [15:0] word, input int nclk,
                       output logic [31:0] rd, output int oe_early);
    rd       = 32'h0;
    oe_early = 0;
    latch_strobe = 1'b0;
    #100;
    for (int i = 0; i < nclk; i++)
    begin
      ctrl_serial_in = (i < 16) ? word[15 - i] : i[0];
      #62.5;
      ctrl_bit_clock = 1'b1;
      if (i < 8 && ctrl_serial_out_oe !== 1'b0)
        oe_early++;
      else if (i >= 8)
        rd = {rd[30:0], ctrl_serial_out_oe ? ctrl_serial_out : 1'bx};
      #62.5;
      ctrl_bit_clock = 1'b0;
    end
    #50;
    latch_strobe = 1'b1;
    ctrl_serial_in = ~ctrl_serial_in;
    #400;
  endtask
endmodule

// ### testbench/smcp_port_tb_top.sv
module smcp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        rst;
  logic        ctrl_bit_clock;
  logic        latch_strobe;
  logic        ctrl_serial_in;
  logic        ctrl_serial_out;
  logic        ctrl_serial_out_oe;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_mismatch;
  int          samples_checked;
  int          cycles;

  smcp_port DUT (.ref_clk(ref_clk), .rst(rst), .ctrl_bit_clock(ctrl_bit_clock),
    .latch_strobe(latch_strobe), .ctrl_serial_in(ctrl_serial_in), .ctrl_serial_out(ctrl_serial_out),
    .ctrl_serial_out_oe(ctrl_serial_out_oe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  smcp_host_model host (.ctrl_bit_clock(ctrl_bit_clock), .latch_strobe(latch_strobe),
    .ctrl_serial_in(ctrl_serial_in), .ctrl_serial_out(ctrl_serial_out),
    .ctrl_serial_out_oe(ctrl_serial_out_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Report and timeout
  // ----------------------------------------
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the global cycle ceiling ends a stalled access
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h0, rd, err);
    chk("apb read data", exp, rd);
    chk("apb read error", {31'h0, exp_err}, {31'h0, err});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_and_map();
    logic [31:0] rd;
    logic        err;
    reg_chk(12'h02c, 32'h01, 1'b0);
    reg_chk(12'h004, 32'h00, 1'b0);
    reg_chk(12'h080, 32'h01, 1'b0);
    reg_chk(12'h090, 32'h00, 1'b1);
    apb(1'b1, 12'h004, 32'h5a, rd, err);
    chk("mode reg apb write refused", 32'h1, {31'h0, err});
    reg_chk(12'h004, 32'h00, 1'b0);
  endtask

  task automatic test_serial_writes();
    logic [31:0] rd;
    int          oe;
    host.frame(16'h05a5, 16, rd, oe);
    reg_chk(12'h014, 32'ha5, 1'b0);
    host.frame(16'h0d77, 16, rd, oe);
    reg_chk(12'h034, 32'h00, 1'b0);
    reg_chk(12'h084, 32'h0000_0500, 1'b0);
    host.frame(16'h0666, 15, rd, oe);
    reg_chk(12'h018, 32'h00, 1'b0);
  endtask

  task automatic test_single_read();
    logic [31:0] rd;
    int          oe;
    host.frame(16'h0b05, 16, rd, oe);
    host.frame(16'h8000, 16, rd, oe);
    chk("single read float", 32'h0, oe);
    chk("single read byte", 32'ha5, rd);
    chk("oe after strobe", 32'h0, {31'h0, ctrl_serial_out_oe});
    host.frame(16'h817f, 16, rd, oe);
    chk("index ignored", 32'ha5, rd);
  endtask

  task automatic test_auto_read();
    logic [31:0] rd;
    int          oe;
    host.frame(16'h133c, 16, rd, oe);
    host.frame(16'h0111, 16, rd, oe);
    host.frame(16'h0b93, 16, rd, oe);
    host.frame(16'h8000, 40, rd, oe);
    chk("auto read float", 32'h0, oe);
    chk("auto read bytes", 32'h3c1100, {8'h00, rd[31:8]});
    chk("auto read after wrap", 32'h0, {24'h0, rd[7:0]});
  endtask

  initial
  begin
    n_mismatch      = 0;
    samples_checked = 0;
    cycles          = 0;
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    test_reset_and_map();
    test_serial_writes();
    test_single_read();
    test_auto_read();
    complete_run();
  end
endmodule
